// >>> hw/posfr_sequencer.sv
`timescale 1ns/100ps
module posfr_sequencer
	import posfr_pkg::*;
#(
	parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic                   reg_word,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [15:0]            reg_wdata,
	output logic      [15:0]            reg_rdata,
	output logic                        reg_rvalid,
	output logic                        reg_err,
	input  wire logic                   enable_cmd,
	input  wire logic                   fault_clear,
	input  wire logic                   uv_reached,
	input  wire logic [7:0]             fault_unit_ms,
	output logic                        output_enable,
	output logic                        ramp_active,
	output logic                        timeout_fault,
	output logic      [2:0]             retry_count,
	output logic      [2:0]             seq_state
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0]       dly;
		logic [15:0]       rise;
		logic [15:0]       lim;
		logic [7:0]        rsp;
		posfr_state_t      st;
		logic [15:0]       ms_cnt;
		logic [15:0]       to_cnt;
		logic [CNT_W-1:0]  unit_cnt;
		logic [2:0]        retries;
		logic              fault;
		logic              en_d;
		logic [15:0]       rdata;
		logic              rvalid;
		logic              err;
		logic              oe;
		logic              ramp;
	} posfr_seq_t;

	posfr_seq_t st_r;
	posfr_seq_t st_nxt;
	logic       tick;
	logic       en_s1_r;
	logic       en_s2_r;
	logic       clr_s1_r;
	logic       clr_s2_r;
	logic       uv_s1_r;
	logic       uv_s2_r;

	posfr_ms_tick #(
		.CYCLES (MS_CYCLES)
	) u_tick (
		.clock (clock),
		.rst   (rst),
		.tick  (tick)
	);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			en_s1_r  <= 1'b0;
			en_s2_r  <= 1'b0;
			clr_s1_r <= 1'b0;
			clr_s2_r <= 1'b0;
			uv_s1_r  <= 1'b0;
			uv_s2_r  <= 1'b0;
		end else begin
			en_s1_r  <= enable_cmd;
			en_s2_r  <= en_s1_r;
			clr_s1_r <= fault_clear;
			clr_s2_r <= clr_s1_r;
			uv_s1_r  <= uv_reached;
			uv_s2_r  <= uv_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// decoded response fields
	// ----------------------------------------------------------------
	logic [1:0]       mode;
	logic [2:0]       rcode;
	logic [2:0]       dcode;
	logic [CNT_W-1:0] wait_ms;
	logic             retry_ok;
	logic             restart;
	logic             clr;

	always_comb begin
		mode  = st_r.rsp[RSP_MODE_HI:RSP_MODE_LO];
		rcode = st_r.rsp[RSP_RETRY_HI:RSP_RETRY_LO];
		dcode = st_r.rsp[RSP_DLY_HI:RSP_DLY_LO];
		// unit shared with output voltage faults, scaled by two-power-n
		wait_ms = CNT_W'({8'h00, fault_unit_ms} << dcode);
		if (wait_ms == '0) begin
			wait_ms = CNT_W'(1);
		end
		// code 110 is outside the supported set; treat as unlimited
		if (rcode > RETRY_MAX_CNT) begin
			retry_ok = 1'b1;
		end else if (rcode == RETRY_NONE) begin
			retry_ok = 1'b0;
		end else begin
			retry_ok = (st_r.retries < rcode);
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;
		st_nxt.err = 1'b0;
		st_nxt.en_d = en_s2_r;
		clr = clr_s2_r || (en_s2_r && !st_r.en_d);
		restart = 1'b0;

		// register writes: word for timings, byte for response
		if (reg_wr) begin
			case (reg_addr)
			ADDR_TURN_ON_DELAY_TIME_TIME: begin
				if (reg_word) st_nxt.dly = reg_wdata;
				else st_nxt.err = 1'b1;
			end
			ADDR_TON_RAMP_TIME: begin
				if (reg_word) st_nxt.rise = reg_wdata;
				else st_nxt.err = 1'b1;
			end
			ADDR_TON_TIMEOUT_LIM: begin
				if (reg_word) st_nxt.lim = reg_wdata;
				else st_nxt.err = 1'b1;
			end
			ADDR_TON_TIMEOUT_RSP: begin
				if (!reg_word) st_nxt.rsp = reg_wdata[7:0];
				else st_nxt.err = 1'b1;
			end
			default: st_nxt.err = 1'b1;
			endcase
		end else if (reg_rd) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = '0;
			case (reg_addr)
			ADDR_TURN_ON_DELAY_TIME_TIME:  st_nxt.rdata = st_r.dly;
			ADDR_TON_RAMP_TIME:   st_nxt.rdata = st_r.rise;
			ADDR_TON_TIMEOUT_LIM: st_nxt.rdata = st_r.lim;
			ADDR_TON_TIMEOUT_RSP: st_nxt.rdata = {8'h00, st_r.rsp};
			default:              st_nxt.err = 1'b1;
			endcase
			if ((reg_addr == ADDR_TON_TIMEOUT_RSP) == reg_word) begin
				st_nxt.err = 1'b1;
			end
		end

		// turn-on timeout watch runs from enable until undervoltage met
		if ((st_r.st == SEQ_DELAY || st_r.st == SEQ_RAMP ||
		     st_r.st == SEQ_ON || st_r.st == SEQ_GRACE) && !uv_s2_r &&
		    st_r.lim != '0 && tick) begin
			if (st_r.to_cnt + 16'h0001 >= st_r.lim) begin
				st_nxt.fault = 1'b1;
			end else begin
				st_nxt.to_cnt = st_r.to_cnt + 16'h0001;
			end
		end

		case (st_r.st)
		SEQ_OFF: begin
			if (en_s2_r) begin
				st_nxt.st = SEQ_DELAY;
				st_nxt.ms_cnt = '0;
				st_nxt.to_cnt = '0;
			end
		end
		SEQ_DELAY: begin
			if (st_r.ms_cnt >= st_r.dly) begin
				st_nxt.st = SEQ_RAMP;
				st_nxt.ms_cnt = '0;
				st_nxt.ramp = 1'b1;
			end else if (tick) begin
				st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
			end
		end
		SEQ_RAMP: begin
			st_nxt.oe = 1'b1;
			if (st_r.ms_cnt >= st_r.rise) begin
				st_nxt.st = SEQ_ON;
				st_nxt.ramp = 1'b0;
			end else if (tick) begin
				st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
			end
		end
		SEQ_ON: begin
			if (uv_s2_r) begin
				st_nxt.to_cnt = '0;
			end
		end
		SEQ_GRACE: begin
			// keep running; retry only if fault still present
			if (uv_s2_r) begin
				st_nxt.st = SEQ_ON;
				st_nxt.fault = 1'b0;
				st_nxt.to_cnt = '0;
			end else if (st_r.unit_cnt >= wait_ms) begin
				restart = 1'b1;
			end else if (tick) begin
				st_nxt.unit_cnt = st_r.unit_cnt + 1'b1;
			end
		end
		SEQ_WAIT_RETRY: begin
			if (st_r.unit_cnt >= wait_ms) begin
				st_nxt.st = SEQ_DELAY;
				st_nxt.ms_cnt = '0;
				st_nxt.to_cnt = '0;
				st_nxt.fault = 1'b0;
				st_nxt.retries = (st_r.retries == RETRY_FOREVER) ?
					st_r.retries : st_r.retries + 3'h1;
			end else if (tick) begin
				st_nxt.unit_cnt = st_r.unit_cnt + 1'b1;
			end
		end
		SEQ_LATCHED: begin
			st_nxt.oe = 1'b0;
		end
		default: st_nxt.st = SEQ_OFF;
		endcase

		// response when the fault is raised this cycle
		if (st_nxt.fault && !st_r.fault) begin
			case (mode)
			MODE_IGNORE: st_nxt.fault = 1'b1;
			MODE_RUN_DLY: begin
				st_nxt.st = SEQ_GRACE;
				st_nxt.unit_cnt = '0;
			end
			MODE_DIS_RTRY: restart = 1'b1;
			default: begin
				st_nxt.st = SEQ_LATCHED;
				st_nxt.oe = 1'b0;
				st_nxt.ramp = 1'b0;
			end
			endcase
		end

		if (restart) begin
			st_nxt.oe = 1'b0;
			st_nxt.ramp = 1'b0;
			st_nxt.unit_cnt = '0;
			st_nxt.st = retry_ok ? SEQ_WAIT_RETRY : SEQ_LATCHED;
		end

		// enable low forces off; clear or off-on restarts cleanly
		if (!en_s2_r) begin
			st_nxt.st = SEQ_OFF;
			st_nxt.oe = 1'b0;
			st_nxt.ramp = 1'b0;
			st_nxt.fault = 1'b0;
			st_nxt.retries = '0;
		end else if (clr && st_r.st != SEQ_OFF) begin
			st_nxt.st = SEQ_DELAY;
			st_nxt.fault = 1'b0;
			st_nxt.retries = '0;
			st_nxt.ms_cnt = '0;
			st_nxt.to_cnt = '0;
			st_nxt.oe = 1'b0;
			st_nxt.ramp = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_r <= '{dly: RST_TURN_ON_DELAY_TIME_TIME, rise: RST_TON_RAMP_TIME,
			          lim: RST_TON_TIMEOUT_LIM, rsp: RST_TON_TIMEOUT_RSP,
			          st: SEQ_OFF, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata     = st_r.rdata;
	assign reg_rvalid    = st_r.rvalid;
	assign reg_err       = st_r.err;
	assign output_enable = st_r.oe;
	assign ramp_active   = st_r.ramp;
	assign timeout_fault = st_r.fault;
	assign retry_count   = st_r.retries;
	assign seq_state     = st_r.st;
endmodule : posfr_sequencer

// >>> hw/posfr_pkg.sv
package posfr_pkg;
	// ----------------------------------------------------------------
	// register offsets, widths and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_TURN_ON_DELAY_TIME_TIME  = 8'h60;
	localparam logic [7:0]  ADDR_TON_RAMP_TIME   = 8'h61;
	localparam logic [7:0]  ADDR_TON_TIMEOUT_LIM = 8'h62;
	localparam logic [7:0]  ADDR_TON_TIMEOUT_RSP = 8'h63;
	localparam logic [15:0] RST_TURN_ON_DELAY_TIME_TIME   = 16'h0000;
	localparam logic [15:0] RST_TON_RAMP_TIME    = 16'h0000;
	localparam logic [15:0] RST_TON_TIMEOUT_LIM  = 16'h0000;
	localparam logic [7:0]  RST_TON_TIMEOUT_RSP  = 8'h00;
	// ----------------------------------------------------------------
	// response register fields
	// ----------------------------------------------------------------
	localparam int RSP_MODE_HI  = 7;
	localparam int RSP_MODE_LO  = 6;
	localparam int RSP_RETRY_HI = 5;
	localparam int RSP_RETRY_LO = 3;
	localparam int RSP_DLY_HI   = 2;
	localparam int RSP_DLY_LO   = 0;
	localparam logic [1:0] MODE_IGNORE   = 2'h0;
	localparam logic [1:0] MODE_RUN_DLY  = 2'h1;
	localparam logic [1:0] MODE_DIS_RTRY = 2'h2;
	localparam logic [1:0] MODE_LATCH    = 2'h3;
	localparam logic [2:0] RETRY_NONE    = 3'h0;
	localparam logic [2:0] RETRY_MAX_CNT = 3'h5;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	// ----------------------------------------------------------------
	// timing and sequencer states
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 125000000;
	localparam int TICK_MS     = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TICK_W      = 17;
	localparam int CNT_W       = 24;
	typedef enum logic [2:0] {
		SEQ_OFF, SEQ_DELAY, SEQ_RAMP, SEQ_ON, SEQ_GRACE, SEQ_WAIT_RETRY,
		SEQ_LATCHED
	} posfr_state_t;
endpackage : posfr_pkg

// >>> hw/posfr_ms_tick.sv
`timescale 1ns/100ps
module posfr_ms_tick
	import posfr_pkg::*;
#(
	parameter int unsigned CYCLES = TICK_CYCLES
) (
	input  wire logic clock,
	input  wire logic rst,
	output logic      tick
);
	typedef struct packed {
		logic [TICK_W-1:0] cnt;
		logic              tick;
	} posfr_tick_t;
	posfr_tick_t st_r;
	posfr_tick_t st_nxt;
	localparam logic [TICK_W-1:0] LAST = TICK_W'(CYCLES - 1);

	// free-running divider, one pulse per millisecond
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt == LAST) begin
			st_nxt.cnt = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick = st_r.tick;
endmodule : posfr_ms_tick

// >>> verif/posfr_monitor.sv
`timescale 1ns/100ps
module posfr_monitor
	import posfr_pkg::*;
#(
	parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic        reg_word,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        reg_err,
	input wire logic        enable_cmd,
	input wire logic        fault_clear,
	input wire logic        uv_reached,
	input wire logic [7:0]  fault_unit_ms,
	input wire logic        output_enable,
	input wire logic        ramp_active,
	input wire logic        timeout_fault,
	input wire logic [2:0]  retry_count,
	input wire logic [2:0]  seq_state
);
	// ----------------------------------------------------------------
	// shadow of the response byte, needed to know the mode in force
	// ----------------------------------------------------------------
	logic       wr_rsp;
	logic [7:0] rsp_r;
	assign wr_rsp = reg_wr && reg_addr == ADDR_TON_TIMEOUT_RSP && !reg_word;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rsp_r <= 8'h00;
		end else if (wr_rsp) begin
			rsp_r <= reg_wdata[7:0];
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_off; !enable_cmd [*6]; endsequence
	sequence s_ramp; seq_state == SEQ_RAMP ##1 seq_state == SEQ_RAMP; endsequence
	property p_rvalid; reg_rd && !reg_wr |=> reg_rvalid; endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read not answered");
	property p_size;
		reg_wr && (reg_addr == ADDR_TON_TIMEOUT_RSP) == reg_word |=> reg_err;
	endproperty
	a_size: assert property (p_size)
		else $error("wrong size write not refused");
	property p_dly; seq_state == SEQ_DELAY |-> !output_enable; endproperty
	a_dly: assert property (p_dly)
		else $error("stage on during turn-on delay");
	property p_ramp; s_ramp |-> output_enable && ramp_active; endproperty
	a_ramp: assert property (p_ramp)
		else $error("ramp without stage on");
	property p_dis;
		rsp_r[7:6] == MODE_DIS_RTRY && $rose(timeout_fault)
			|-> ##[0:1] !output_enable;
	endproperty
	a_dis: assert property (p_dis)
		else $error("stage not disabled on fault");
	property p_latch; seq_state == SEQ_LATCHED |-> !output_enable; endproperty
	a_latch: assert property (p_latch)
		else $error("stage on while latched off");
	property p_rmax;
		rsp_r[5:3] inside {[3'h1:RETRY_MAX_CNT]} |-> retry_count <= rsp_r[5:3];
	endproperty
	a_rmax: assert property (p_rmax)
		else $error("too many restarts");
	property p_off;
		s_off |-> !output_enable && !timeout_fault && retry_count == 3'h0;
	endproperty
	a_off: assert property (p_off)
		else $error("off command did not clear");
endmodule : posfr_monitor

bind posfr_sequencer posfr_monitor #(.MS_CYCLES(MS_CYCLES)) posfr_monitor_i (.*);

// >>> verif/posfr_host_model.sv
`timescale 1ns/100ps
module posfr_host_model (
	input  wire logic        clock,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic             reg_word,
	output logic [7:0]       reg_addr,
	output logic [15:0]      reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid,
	input  wire logic        reg_err,
	input  wire logic        output_enable,
	input  wire logic        plant_ok,
	output logic             uv_reached
);
	logic [2:0] ramp_r = 3'h0;
	initial begin
		{reg_wr, reg_rd, reg_word, reg_addr, reg_wdata} = '0;
	end
	// output crosses the undervoltage limit three cycles after turn-on, and only while plant_ok is high
	always @(posedge clock) ramp_r <= {ramp_r[1:0], output_enable & plant_ok};
	assign uv_reached = ramp_r[2];
	task xfer(input logic r, input logic [7:0] a, input logic w,
		input logic [15:0] d, output logic [15:0] q, output logic e);
		@(posedge clock);
		#1;
		{reg_wr, reg_rd, reg_word, reg_addr, reg_wdata} = {!r, r, w, a, d};
		@(posedge clock);
		#1;
		// released lines stop showing the last value
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
		q = reg_rdata;
		e = reg_err;
	endtask : xfer
endmodule : posfr_host_model

// >>> verif/tb_power_on_sequence_fault_retry.sv
`timescale 1ns/100ps
module tb_power_on_sequence_fault_retry;
	import posfr_pkg::*;
	logic        clock, rst, enable_cmd, fault_clear, plant_ok, e;
	logic        reg_wr, reg_rd, reg_word, reg_rvalid, reg_err, uv_reached;
	logic        output_enable, ramp_active, timeout_fault;
	logic [7:0]  reg_addr, fault_unit_ms;
	logic [15:0] reg_wdata, reg_rdata, q;
	logic [2:0]  retry_count, seq_state;
	int          error_cnt, check_count, n;
	posfr_sequencer #(.MS_CYCLES(10)) posfr_sequencer_i (.*);
	posfr_host_model posfr_host_model_i (.*);
	task chk(input string s, input logic [15:0] x, input logic [15:0] g);
		check_count++;
		if (g !== x) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", s, x, g);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : cyc
	task wr(input logic [7:0] a, input logic w, input logic [15:0] d);
		posfr_host_model_i.xfer(1'b0, a, w, d, q, e);
	endtask : wr
	task set(input logic [15:0] d, r, l, input logic [7:0] p);
		enable_cmd = 1'b0;
		cyc(6);
		wr(ADDR_TURN_ON_DELAY_TIME_TIME, 1'b1, d);
		wr(ADDR_TON_RAMP_TIME, 1'b1, r);
		wr(ADDR_TON_TIMEOUT_LIM, 1'b1, l);
		wr(ADDR_TON_TIMEOUT_RSP, 1'b0, {8'h00, p});
		enable_cmd = 1'b1;
	endtask : set
	task w_oe(input logic v);
		for (n = 0; output_enable !== v && n < 900; n++) cyc(1);
	endtask : w_oe
	task w_flt;
		for (n = 0; timeout_fault !== 1'b1 && n < 900; n++) cyc(1);
	endtask : w_flt
	task t_regs;
		posfr_host_model_i.xfer(1'b1, ADDR_TON_TIMEOUT_RSP, 1'b0, 16'h0, q, e);
		chk("rsp reset", 16'(RST_TON_TIMEOUT_RSP), q);
		wr(ADDR_TON_TIMEOUT_RSP, 1'b0, 16'h00a5);
		wr(ADDR_TON_TIMEOUT_RSP, 1'b1, 16'h5a5a);
		chk("word err", 16'h1, 16'(e));
		wr(ADDR_TON_RAMP_TIME, 1'b0, 16'h0011);
		chk("byte err", 16'h1, 16'(e));
		wr(8'h64, 1'b1, 16'h0001);
		chk("unmapped err", 16'h1, 16'(e));
		posfr_host_model_i.xfer(1'b1, ADDR_TON_TIMEOUT_RSP, 1'b0, 16'h0, q, e);
		chk("rsp kept", 16'h00a5, q);
	endtask : t_regs
	task t_seq;
		set(16'h0005, 16'h0002, 16'h0000, 8'h80);
		w_oe(1'b1);
		chk("delay span", 16'h1, 16'(n >= 43 && n <= 57));
		for (n = 0; ramp_active === 1'b1 && n < 900; n++) cyc(1);
		chk("ramp span", 16'h1, 16'(n >= 18 && n <= 22));
		cyc(300);
		chk("no limit", 16'h0, 16'(timeout_fault));
		posfr_host_model_i.xfer(1'b1, ADDR_TURN_ON_DELAY_TIME_TIME, 1'b1, 16'h0, q, e);
		chk("dly read", 16'h0005, q);
		chk("dly read err", 16'h0, 16'(e));
	endtask : t_seq
	task t_ignore;
		set(16'h0000, 16'h0000, 16'h0004, 8'h00);
		w_flt;
		chk("fault time", 16'h1, 16'(n >= 30 && n <= 47));
		cyc(50);
		chk("ignored", 16'(SEQ_ON), 16'(seq_state));
	endtask : t_ignore
	task t_latch;
		set(16'h0000, 16'h0000, 16'h0004, 8'hc0);
		w_flt;
		cyc(100);
		chk("latched", 16'(SEQ_LATCHED), 16'(seq_state));
		fault_clear = 1'b1;
		plant_ok = 1'b1;
		cyc(5);
		fault_clear = 1'b0;
		chk("cleared", 16'h0, 16'(timeout_fault));
		cyc(80);
		chk("uv in time", 16'h0, 16'(timeout_fault));
	endtask : t_latch
	task t_retry;
		plant_ok = 1'b0;
		fault_unit_ms = 8'h02;
		set(16'h0000, 16'h0000, 16'h0002, 8'h91);
		w_flt;
		w_oe(1'b0);
		chk("off at once", 16'h1, 16'(n <= 1));
		w_oe(1'b1);
		chk("retry gap", 16'h1, 16'(n >= 30 && n <= 50));
		cyc(400);
		chk("retries", 16'h2, 16'(retry_count));
		chk("gave up", 16'(SEQ_LATCHED), 16'(seq_state));
	endtask : t_retry
	task t_grace;
		fault_unit_ms = 8'h01;
		set(16'h0000, 16'h0000, 16'h0002, 8'h42);
		w_flt;
		cyc(20);
		chk("grace on", 16'h1, 16'(output_enable));
		cyc(30);
		chk("grace off", 16'h0, 16'(output_enable));
		chk("no retry", 16'(SEQ_LATCHED), 16'(seq_state));
	endtask : t_grace
	task t_forever;
		for (int c = 6; c <= 7; c++) begin
			set(16'h0000, 16'h0000, 16'h0001, {2'b10, 3'(c), 3'h0});
			cyc(400);
			chk("forever", 16'h1, 16'(seq_state !== SEQ_LATCHED));
		end
	endtask : t_forever
	task summarize;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// bounded at 25000 cycles, over ten times the longest expected run of about 2200 cycles
	initial begin
		#200000;
		error_cnt++;
		summarize();
	end
	initial begin
		{rst, enable_cmd, fault_clear, plant_ok} = 4'h8;
		fault_unit_ms = 8'h01;
		repeat (12) @(posedge clock);
		#1;
		rst = 1'b0;
		t_regs();
		t_seq();
		t_ignore();
		t_latch();
		t_retry();
		t_grace();
		t_forever();
		summarize();
	end
endmodule : tb_power_on_sequence_fault_retry
